// *** rtl/ats_consts.svh ***
// constants of the axis target and speed override block
// assumes inclusion by bare name from the rtl files
`ifndef ATS_CONSTS_SVH
`define ATS_CONSTS_SVH
// -----------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------
`define ATS_A_OPSPD 8'h00
`define ATS_A_INSPD 8'h04
`define ATS_A_ACCR 8'h08
`define ATS_A_DECR 8'h0c
`define ATS_A_ACCS 8'h10
`define ATS_A_DECS 8'h14
`define ATS_A_FEED 8'h18
`define ATS_A_MODE 8'h1c
`define ATS_A_ENV1 8'h20
`define ATS_A_CMD 8'h24
`define ATS_A_STS 8'h28
`define ATS_A_POS 8'h2c
`define ATS_A_RDP 8'h30
// -----------------------------------------------------------
// field positions
// -----------------------------------------------------------
`define ATS_MODE_SCURVE 0
`define ATS_MODE_RDP_MAN 1
`define ATS_MODE_INP_WAIT 2
`define ATS_MODE_DELAYED 14
`define ATS_ENV1_CS_POL 24
`define ATS_STS_CS 8
`define ATS_STS_RUN 9
`define ATS_STS_END 10
// -----------------------------------------------------------
// command codes, condition codes, reset values
// -----------------------------------------------------------
`define ATS_CMD_START_LO 8'h01
`define ATS_CMD_START_HI 8'h02
`define ATS_CMD_STOP 8'h03
`define ATS_CMD_DEC_STOP 8'h04
`define ATS_CMD_CNT_START 8'h05
`define ATS_CND_IDLE 4'h0
`define ATS_CND_WAIT_INP 4'h5
`define ATS_CND_BACKLASH 4'h7
`define ATS_CND_LOW 4'ha
`define ATS_CND_ACCEL 4'hb
`define ATS_CND_HIGH 4'hc
`define ATS_CND_DECEL 4'hd
`define ATS_RST_REG 32'h0000_0000
`define ATS_RST_PINS 6'h3f
`endif

// *** rtl/ats_pkg.sv ***
// types shared by the axis override block files
// assumes nothing beyond a SystemVerilog compiler
package ats_pkg;
    // top-level motion state
    typedef enum logic [1:0] {
        ats_st_idle,
        ats_st_run,
        ats_st_wait
    } ats_state_t;
    // speed ramp settings handed to the ramp engine
    typedef struct packed {
        logic [15:0] floor;
        logic [15:0] target;
        logic [15:0] rate_up;
        logic [15:0] rate_dn;
        logic [15:0] srange_up;
        logic [15:0] srange_dn;
        logic scurve;
    } ats_ramp_cfg_t;
    // driver-facing pins, all active low except dir
    typedef struct packed {
        logic pulse_n;
        logic dir;
        logic busy_n;
        logic up_n;
        logic dn_n;
        logic const_n;
    } ats_drv_t;
endpackage

// *** rtl/ats_ramp.sv ***
// speed ramp engine: steps the speed toward a target
// assumes one clock, settings that may change at any cycle
`timescale 1ns/10ps
module ats_ramp (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // control
    input wire logic load,
    input wire ats_pkg::ats_ramp_cfg_t cfg,
    // speed state
    output logic [15:0] speed,
    output logic rising,
    output logic falling
);
    // -------------------------------------------------------
    // step decisions, all from live settings
    // -------------------------------------------------------
    logic [15:0] div; // interval counter
    logic half; // second half of a slow curve interval
    wire up_w = speed < cfg.target;
    wire dn_w = speed > cfg.target;
    wire [15:0] rate = up_w ? cfg.rate_up : cfg.rate_dn;
    wire [15:0] srng = up_w ? cfg.srange_up : cfg.srange_dn;
    wire [15:0] to_go = up_w ? cfg.target - speed
                             : speed - cfg.target;
    wire [15:0] from_base = speed - cfg.floor;
    // curve ends run at half slope, giving the S shape
    wire in_curve = cfg.scurve &
        ((to_go <= srng) | (from_base <= srng));
    wire expire = div >= rate;
    wire step = expire & (~in_curve | half);
    assign rising = up_w;
    assign falling = dn_w;
    // speed and interval counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed <= 16'h0000;
            div <= 16'h0000;
            half <= 1'b0;
        end else if (ce) begin
            if (load) begin // move start at the base speed
                speed <= cfg.floor;
                div <= 16'h0000;
                half <= 1'b0;
            end else if (up_w | dn_w) begin
                div <= expire ? 16'h0000 : div + 16'h0001;
                if (expire)
                    half <= in_curve & ~half;
                if (step)
                    speed <= up_w ? speed + 16'h0001
                                  : speed - 16'h0001;
            end else begin // on target: ramp is done
                div <= 16'h0000;
                half <= 1'b0;
            end
        end
    end
endmodule // ats_ramp

// *** rtl/ats_axis.sv ***
// one pulse-train axis with on-the-fly speed and target
// override, delayed counting, APB register access
// assumes APB master on pclk; driver pins synchronous
`timescale 1ns/10ps
`include "ats_consts.svh"
module ats_axis (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // machine inputs
    input wire logic in_position_input,
    input wire logic count_start_input,
    // driver pins
    output ats_pkg::ats_drv_t drv
);
    // -------------------------------------------------------
    // software registers
    // -------------------------------------------------------
    logic [15:0] operating_speed_reg;
    logic [15:0] initial_speed_reg;
    logic [15:0] accel_rate_reg;
    logic [15:0] decel_rate_reg;
    logic [15:0] accel_scurve_range;
    logic [15:0] decel_scurve_range;
    logic [27:0] feed_amount_reg; // signed travel
    logic [15:0] mode_reg;
    logic [31:0] environment_config_one;
    logic [23:0] ramp_down_reg; // manual ramp-down point
    // -------------------------------------------------------
    // motion state
    // -------------------------------------------------------
    ats_pkg::ats_state_t state;
    ats_pkg::ats_state_t next_state;
    logic [28:0] travelled; // signed, from move start
    logic [23:0] phase; // pulse rate accumulator
    logic [23:0] accel_pulses; // pulses spent accelerating
    logic [15:0] hold_spd; // old target kept during S accel
    logic dir_pos; // travelling positive
    logic hs_mode; // started at high speed
    logic reversing; // braking to turn round
    logic counting; // feed count running
    logic stop_req; // decelerate-and-stop pending
    logic end_flag; // operation ended
    logic hold_active;
    logic ramp_load;
    logic [15:0] speed;
    logic rising;
    logic falling;
    // -------------------------------------------------------
    // apb decode
    // -------------------------------------------------------
    wire acc = psel & penable & pready;
    wire wr_en = acc & pwrite;
    wire sel_op = paddr == `ATS_A_OPSPD;
    wire sel_in = paddr == `ATS_A_INSPD;
    wire sel_ar = paddr == `ATS_A_ACCR;
    wire sel_dr = paddr == `ATS_A_DECR;
    wire sel_as = paddr == `ATS_A_ACCS;
    wire sel_ds = paddr == `ATS_A_DECS;
    wire sel_fd = paddr == `ATS_A_FEED;
    wire sel_md = paddr == `ATS_A_MODE;
    wire sel_e1 = paddr == `ATS_A_ENV1;
    wire sel_cm = paddr == `ATS_A_CMD;
    wire sel_st = paddr == `ATS_A_STS;
    wire sel_ps = paddr == `ATS_A_POS;
    wire sel_rd = paddr == `ATS_A_RDP;
    wire mapped = sel_op | sel_in | sel_ar | sel_dr | sel_as |
        sel_ds | sel_fd | sel_md | sel_e1 | sel_cm | sel_st |
        sel_ps | sel_rd;
    wire cmd_w = wr_en & sel_cm;
    wire cmd_lo = cmd_w & (pwdata[7:0] == `ATS_CMD_START_LO);
    wire cmd_hi = cmd_w & (pwdata[7:0] == `ATS_CMD_START_HI);
    wire cmd_stop = cmd_w & (pwdata[7:0] == `ATS_CMD_STOP);
    wire cmd_dstp = cmd_w & (pwdata[7:0] == `ATS_CMD_DEC_STOP);
    wire cmd_cs = cmd_w & (pwdata[7:0] == `ATS_CMD_CNT_START);
    // -------------------------------------------------------
    // motion decode
    // -------------------------------------------------------
    wire running = state != ats_pkg::ats_st_run ?
        state == ats_pkg::ats_st_wait : 1'b1;
    wire in_run = state == ats_pkg::ats_st_run;
    wire go = (cmd_lo | cmd_hi) & (state == ats_pkg::ats_st_idle);
    // polarity select of the count-start input
    wire cs_active = environment_config_one[`ATS_ENV1_CS_POL] ?
        count_start_input : ~count_start_input;
    wire [28:0] remaining = {feed_amount_reg[27], feed_amount_reg}
        - travelled;
    wire [28:0] rem_abs = remaining[28] ? 29'h0 - remaining
                                        : remaining;
    wire arrive = in_run & counting & (remaining == 29'h0);
    // overshot or target now behind the travel direction
    wire wrong_way = in_run & counting & ~arrive &
        (dir_pos == remaining[28]);
    wire [23:0] down_pts = mode_reg[`ATS_MODE_RDP_MAN] ?
        ramp_down_reg : accel_pulses;
    // inside the ramp-down zone; leaving it re-accelerates
    wire near_end = hs_mode & counting &
        (rem_abs <= {5'h00, down_pts});
    wire at_floor = speed <= initial_speed_reg;
    wire [15:0] eff_op = hold_active ? hold_spd
                                     : operating_speed_reg;
    // low-speed starts never leave the base speed
    wire brake = ~hs_mode | reversing | near_end | stop_req;
    wire [15:0] ramp_target = brake ? initial_speed_reg : eff_op;
    // whole bundle in one assignment, in the field order of the struct
    ats_pkg::ats_ramp_cfg_t cfg;
    assign cfg = {initial_speed_reg, ramp_target,
        accel_rate_reg, decel_rate_reg, accel_scurve_range,
        decel_scurve_range, mode_reg[`ATS_MODE_SCURVE]};
    wire [24:0] phase_sum = {1'b0, phase} + {9'h000, speed};
    wire pulse = in_run & ~arrive & phase_sum[24];
    // condition code as software sees it
    wire [3:0] cond = state == ats_pkg::ats_st_wait ?
        `ATS_CND_WAIT_INP : ~in_run ? `ATS_CND_IDLE :
        rising ? `ATS_CND_ACCEL : falling ? `ATS_CND_DECEL :
        (hs_mode & ~at_floor) ? `ATS_CND_HIGH : `ATS_CND_LOW;
    // feed rewrite gate; wait codes are absent from the set
    wire rewrite_ok = running & ((cond == `ATS_CND_BACKLASH) |
        (cond == `ATS_CND_LOW) | (cond == `ATS_CND_ACCEL) |
        (cond == `ATS_CND_HIGH) | (cond == `ATS_CND_DECEL));
    wire feed_wr = wr_en & sel_fd &
        (~running | rewrite_ok);
    // higher speed during S accel: keep old target first
    wire hold_set = wr_en & sel_op & in_run & cfg.scurve &
        rising & ~hold_active &
        (pwdata[15:0] > operating_speed_reg);
    wire end_run = cmd_stop | arrive | (stop_req & at_floor);
    wire [15:0] sts = {5'h00, end_flag, running, cs_active,
        4'h0, cond};
    wire [31:0] rd_mux =
        sel_op ? {16'h0000, operating_speed_reg} :
        sel_in ? {16'h0000, initial_speed_reg} :
        sel_ar ? {16'h0000, accel_rate_reg} :
        sel_dr ? {16'h0000, decel_rate_reg} :
        sel_as ? {16'h0000, accel_scurve_range} :
        sel_ds ? {16'h0000, decel_scurve_range} :
        sel_fd ? {4'h0, feed_amount_reg} :
        sel_md ? {16'h0000, mode_reg} :
        sel_e1 ? environment_config_one :
        sel_st ? {16'h0000, sts} :
        sel_ps ? {{3{travelled[28]}}, travelled} :
        sel_rd ? {8'h00, ramp_down_reg} : `ATS_RST_REG;
    assign next_state =
        (state == ats_pkg::ats_st_idle) ?
            (go ? ats_pkg::ats_st_run : ats_pkg::ats_st_idle) :
        (state == ats_pkg::ats_st_run) ? (~end_run ? state :
            (mode_reg[`ATS_MODE_INP_WAIT] & ~cmd_stop) ?
            ats_pkg::ats_st_wait : ats_pkg::ats_st_idle) :
        (in_position_input | cmd_stop) ? ats_pkg::ats_st_idle :
            state;
    // -------------------------------------------------------
    // ramp engine
    // -------------------------------------------------------
    ats_ramp u_ramp (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(ramp_load),
        .cfg(cfg),
        .speed(speed),
        .rising(rising),
        .falling(falling)
    );
    // -------------------------------------------------------
    // apb response, zero wait states
    // -------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `ATS_RST_REG;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel & ~penable & ~pready;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
            pslverr <= psel & ~penable & ~mapped;
        end
    end
    // setting registers, taken at once while moving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operating_speed_reg <= 16'(`ATS_RST_REG);
            initial_speed_reg <= 16'(`ATS_RST_REG);
            accel_rate_reg <= 16'(`ATS_RST_REG);
            decel_rate_reg <= 16'(`ATS_RST_REG);
            accel_scurve_range <= 16'(`ATS_RST_REG);
            decel_scurve_range <= 16'(`ATS_RST_REG);
            mode_reg <= 16'(`ATS_RST_REG);
            environment_config_one <= `ATS_RST_REG;
            ramp_down_reg <= 24'(`ATS_RST_REG);
        end else if (ce & wr_en) begin
            if (sel_op) operating_speed_reg <= pwdata[15:0];
            if (sel_in) initial_speed_reg <= pwdata[15:0];
            if (sel_ar) accel_rate_reg <= pwdata[15:0];
            if (sel_dr) decel_rate_reg <= pwdata[15:0];
            if (sel_as) accel_scurve_range <= pwdata[15:0];
            if (sel_ds) decel_scurve_range <= pwdata[15:0];
            if (sel_md) mode_reg <= pwdata[15:0];
            if (sel_e1) environment_config_one <= pwdata;
            if (sel_rd) ramp_down_reg <= pwdata[23:0];
        end
    end
    // feed amount, guarded while moving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            feed_amount_reg <= 28'(`ATS_RST_REG);
        else if (ce & feed_wr)
            feed_amount_reg <= pwdata[27:0];
    end
    // state, move setup and end flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ats_pkg::ats_st_idle;
            hs_mode <= 1'b0;
            ramp_load <= 1'b0;
            end_flag <= 1'b0;
            stop_req <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            ramp_load <= go;
            if (go) hs_mode <= cmd_hi;
            // end wins over the start clear
            end_flag <= (running & (next_state ==
                ats_pkg::ats_st_idle)) | (end_flag & ~go);
            stop_req <= running & ~go & (stop_req | cmd_dstp);
        end
    end
    // delayed count gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            counting <= 1'b0;
        else if (ce) begin
            if (go)
                counting <= ~mode_reg[`ATS_MODE_DELAYED];
            else if (in_run & (cs_active | cmd_cs))
                counting <= 1'b1;
        end
    end
    // pulse accumulator and travelled distance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 24'(`ATS_RST_REG);
            travelled <= 29'(`ATS_RST_REG);
        end else if (ce) begin
            phase <= in_run ? phase_sum[23:0] : 24'h000000;
            if (go)
                travelled <= 29'h0;
            else if (pulse & counting)
                travelled <= dir_pos ? travelled + 29'h1
                                     : travelled - 29'h1;
        end
    end
    // direction and turn-round
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_pos <= 1'b0;
            reversing <= 1'b0;
        end else if (ce) begin
            if (go) begin
                dir_pos <= ~feed_amount_reg[27];
                reversing <= 1'b0;
            end else if ((reversing | wrong_way) & at_floor) begin
                dir_pos <= ~dir_pos;
                reversing <= 1'b0;
            end else if (wrong_way)
                reversing <= 1'b1;
        end
    end
    // ramp-down distance learned while accelerating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            accel_pulses <= 24'(`ATS_RST_REG);
        else if (ce) begin
            if (go)
                accel_pulses <= 24'h000000;
            else if (pulse & rising & hs_mode &
                     (accel_pulses != 24'hffffff))
                accel_pulses <= accel_pulses + 24'h000001;
        end
    end
    // held target for a raised speed during S accel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_active <= 1'b0;
            hold_spd <= 16'(`ATS_RST_REG);
        end else if (ce) begin
            if (hold_set) begin
                hold_active <= 1'b1;
                hold_spd <= operating_speed_reg;
            end else if (~in_run | (speed >= hold_spd))
                hold_active <= 1'b0;
        end
    end
    // driver pins, all high in reset; while idle all high except dir, which keeps the last direction or, after a stop mid turn-round, flips at base speed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drv <= ats_pkg::ats_drv_t'(`ATS_RST_PINS);
        else if (ce) begin
            drv.pulse_n <= ~pulse;
            drv.dir <= ~dir_pos;
            drv.busy_n <= ~running;
            drv.up_n <= ~(in_run & rising);
            drv.dn_n <= ~(in_run & falling);
            drv.const_n <= ~(in_run & ~rising & ~falling);
        end
    end
    // -------------------------------------------------------
    // assertions
    // -------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    refused_rewrite_a: assert property (ce & wr_en & sel_fd &
        running & ~rewrite_ok |=> $stable(feed_amount_reg))
        else $error("refused feed rewrite changed target");
    taken_rewrite_a: assert property (ce & wr_en & sel_fd &
        rewrite_ok |=> feed_amount_reg == $past(pwdata[27:0]))
        else $error("accepted feed rewrite not stored");
    wait_refuse_a: assert property (
        state == ats_pkg::ats_st_wait & ce & wr_en & sel_fd
        |=> $stable(feed_amount_reg))
        else $error("feed rewritten while waiting");
    cs_status_a: assert property (ce & psel & ~penable &
        ~pwrite & sel_st |=> prdata[8] == $past(cs_active))
        else $error("count-start status bit wrong");
    delayed_hold_a: assert property (ce & in_run & ~counting
        & ~cs_active & ~cmd_cs & ~go |=> $stable(travelled))
        else $error("counted before count start");
    cs_command_a: assert property (ce & in_run & cmd_cs
        |=> counting)
        else $error("count-start command ignored");
    reverse_turn_a: assert property (ce & in_run & reversing
        & at_floor & ~go |=> dir_pos != $past(dir_pos))
        else $error("no turn at base speed");
    hold_speed_a: assert property (ce & hold_set
        |=> hold_active && cfg.target <= $past(operating_speed_reg))
        else $error("raised speed not deferred");
    reset_pins_a: assert property (@(posedge pclk)
        disable iff (1'b0) !presetn |-> drv == `ATS_RST_PINS)
        else $error("driver pins not high in reset");
    rewrite_cov: cover property (ce & feed_wr & running);
    reverse_cov: cover property (ce & reversing & at_floor);
    cs_cmd_cov: cover property (ce & in_run & cmd_cs & ~counting);
    hold_cov: cover property (ce & hold_set);
    wait_cov: cover property (ce & wr_en & sel_fd &
        state == ats_pkg::ats_st_wait);
endmodule // ats_axis

// *** verif/ats_drv_model.sv ***
// motor driver model: counts command pulses by direction
// assumes drv pins registered on pclk, dir low = positive
`timescale 1ns/10ps
module ats_drv_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // driver pins, travelled count
    input wire ats_pkg::ats_drv_t drv,
    output logic signed [31:0] pos
);
    // one step for each low pulse cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pos <= 32'sh0;
        else if (!drv.pulse_n) pos <= drv.dir ? pos - 1 : pos + 1;
    end
endmodule // ats_drv_model

// *** verif/testbench.sv ***
// self-checking bench for the axis override block
// assumes apb answers after setup, driver model on drv
`timescale 1ns/10ps
`include "ats_consts.svh"
module testbench;
    // ----------------------------------------------------------
    // signals and table
    // ----------------------------------------------------------
    logic pclk = 0, presetn = 1, ce = 1, psel = 0, penable = 0;
    logic pwrite = 0, in_position_input = 0, count_start_input = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    ats_pkg::ats_drv_t drv;
    logic signed [31:0] pos;
    int n_fail = 0, checked = 0;
    // row: address, write value, read value, error flag
    typedef struct {logic [7:0] a; logic [31:0] d, x; logic e;} ats_row_t;
    ats_row_t rows [8] = '{
        '{`ATS_A_OPSPD, 32'hffff, 32'hffff, 0},
        '{`ATS_A_INSPD, 32'hf000, 32'hf000, 0},
        '{`ATS_A_ACCR, 32'h1, 32'h1, 0}, '{`ATS_A_DECR, 32'h1, 32'h1, 0},
        '{`ATS_A_ACCS, 32'h2, 32'h2, 0}, '{`ATS_A_MODE, 32'h0, 32'h0, 0},
        '{`ATS_A_CMD, 32'h0, 32'h0, 0}, '{8'h40, 32'h1, 32'h0, 1}};
    always #25 pclk = ~pclk;
    ats_axis ats_axis_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_position_input(in_position_input),
        .count_start_input(count_start_input), .drv(drv));
    ats_drv_model ats_drv_model_i (.pclk(pclk), .presetn(presetn),
        .drv(drv), .pos(pos));
    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        checked++;
        if (g !== x) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", n, x, g);
        end
    endtask
    // one apb transfer, held until pready seen at an edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        chk("pready", 1, pready);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // poll status until the end flag sets
    task automatic wait_end();
        for (int n = 0; n < 2000; n++) begin
            apb(0, `ATS_A_STS, 0, rd, er);
            if (rd[`ATS_STS_END] === 1'b1) break;
        end
        chk("end_flag", 1, rd[`ATS_STS_END]);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        #(50 * 60000);
        n_fail++;
        tally_and_finish();
    end
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        presetn <= 0;
        repeat (10) @(posedge pclk);
        chk("rst_drv", 6'h3f, drv);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0, rd, er);
            chk("rst_reg", 0, rd);
            apb(1, rows[i].a, rows[i].d, rd, er);
            chk("err", rows[i].e, er);
            apb(0, rows[i].a, 0, rd, er);
            chk("reg", rows[i].x, rd);
        end
        // active-low count start, then active-high
        repeat (4) @(posedge pclk);
        apb(0, `ATS_A_STS, 0, rd, er);
        chk("cs_lo_act", 1, rd[`ATS_STS_CS]);
        apb(1, `ATS_A_ENV1, 32'h0100_0000, rd, er);
        count_start_input <= 1;
        repeat (4) @(posedge pclk);
        apb(0, `ATS_A_STS, 0, rd, er);
        chk("cs_hi_act", 1, rd[`ATS_STS_CS]);
        count_start_input <= 0;
        // move of 6, rewritten to 10 at low speed
        apb(1, `ATS_A_FEED, 6, rd, er);
        apb(1, `ATS_A_CMD, `ATS_CMD_START_LO, rd, er);
        repeat (20) @(posedge pclk);
        chk("busy", 0, drv.busy_n);
        chk("ramp_pins", 3'b110, drv[2:0]);
        apb(1, `ATS_A_FEED, 10, rd, er);
        wait_end();
        chk("drv_pos", 10, pos);
        apb(0, `ATS_A_POS, 0, rd, er);
        chk("pos_reg", 10, rd);
        // delayed count, released by command
        apb(1, `ATS_A_MODE, 32'h4000, rd, er);
        apb(1, `ATS_A_FEED, 3, rd, er);
        apb(1, `ATS_A_CMD, `ATS_CMD_START_LO, rd, er);
        repeat (2000) @(posedge pclk);
        apb(0, `ATS_A_STS, 0, rd, er);
        chk("held_end", 0, rd[`ATS_STS_END]);
        chk("held_run", 1, rd[`ATS_STS_RUN]);
        apb(0, `ATS_A_POS, 0, rd, er);
        chk("held_pos", 0, rd);
        apb(1, `ATS_A_CMD, `ATS_CMD_CNT_START, rd, er);
        wait_end();
        apb(0, `ATS_A_POS, 0, rd, er);
        chk("cs_pos", 3, rd);
        // in-position wait refuses a feed rewrite
        apb(1, `ATS_A_MODE, 32'h4, rd, er);
        apb(1, `ATS_A_FEED, 2, rd, er);
        apb(1, `ATS_A_CMD, `ATS_CMD_START_LO, rd, er);
        do apb(0, `ATS_A_STS, 0, rd, er);
        while (rd[3:0] !== `ATS_CND_WAIT_INP && drv.busy_n === 1'b0);
        chk("wait_cnd", `ATS_CND_WAIT_INP, rd[3:0]);
        apb(1, `ATS_A_FEED, 7, rd, er);
        apb(0, `ATS_A_FEED, 0, rd, er);
        chk("wait_feed", 2, rd);
        in_position_input <= 1;
        wait_end();
        in_position_input <= 0;
        apb(0, `ATS_A_POS, 0, rd, er);
        chk("inp_pos", 2, rd);
        // reset in mid-move: pins high, registers cleared
        apb(1, `ATS_A_FEED, 100, rd, er);
        apb(1, `ATS_A_CMD, `ATS_CMD_START_LO, rd, er);
        repeat (20) @(posedge pclk);
        chk("rst2_busy", 0, drv.busy_n);
        presetn <= 0;
        repeat (10) @(posedge pclk);
        chk("rst2_drv", 6'h3f, drv);
        presetn <= 1;
        apb(0, `ATS_A_OPSPD, 0, rd, er);
        chk("rst2_op", 0, rd);
        apb(0, `ATS_A_FEED, 0, rd, er);
        chk("rst2_feed", 0, rd);
        tally_and_finish();
    end
endmodule // testbench
